// File: slp_regs.sv
// periodic frame list origin and next queue head pointer register bank
//
// What this block does
// - In wide mode the upper 32 address bits come from the segment register.
// - Origin combines with microframe counter to step through list entries.
// - Origin is 20 bits at 31..12 mapping address 31..12; 11..0 reserved.
// - The 32-bit queue head pointer holds the next queue head address.
// - Queue head pointer bits 4..0 always read back as zero.
// - Counter bits N..3 index the list; N is 12, 11 or 10.
`timescale 1ns/10ps

module slp_regs
    import slp_pkg::*;
#(
    parameter int unsigned COUNTER_W = 14
)
(
    input  wire logic                 clk_sys_i,
    input  wire logic                 reset_n_i,
    // register port
    input  wire logic [7:0]           reg_addr_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    input  wire logic [3:0]           reg_be_i,
    input  wire logic [31:0]          reg_wdata_i,
    output      logic [31:0]          reg_rdata_o,
    output      logic                 reg_rvalid_o,
    // neighbouring operational state
    input  wire logic                 wide_addressing_capable_i,
    input  wire logic [31:0]          upper_address_segment_i,
    input  wire logic [COUNTER_W-1:0] microframe_counter_i,
    input  wire logic [1:0]           list_size_select_i,
    // addresses handed to the schedule engines
    output      logic [31:0]          periodic_list_origin_o,
    output      logic [31:0]          next_queue_head_pointer_o,
    output      logic [63:0]          periodic_fetch_addr_o,
    output      logic [63:0]          queue_head_addr_o,
    output      logic                 periodic_entry_step_o,
    output      logic                 list_size_bad_o
);

    // ********************************************************************
    // storage
    // ********************************************************************
    // only the implemented bits are kept; everything below the field
    // reads as constant zero, so a stray reserved write cannot stick
    logic [31-SLP_ORIGIN_LSB:0] origin_field;
    logic [31-SLP_QH_LSB:0]     queue_head_link_field;

    logic [31:0]                origin_word;
    logic [31:0]                qh_word;
    logic [31:0]                merged_origin;
    logic [31:0]                merged_qh;

    logic                       hit_origin;
    logic                       hit_qh;

    logic [SLP_INDEX_W-1:0]     next_index;
    logic [SLP_INDEX_W-1:0]     index_q;
    logic                       next_size_bad;
    logic [31:0]                periodic_low;
    logic [63:0]                periodic_full;
    logic [63:0]                qh_full;

    // ********************************************************************
    // readback words
    // ********************************************************************
    assign origin_word = {origin_field, {SLP_ORIGIN_LSB{1'b0}}};
    assign qh_word     = {queue_head_link_field, {SLP_QH_LSB{1'b0}}};

    // address decode
    assign hit_origin = (reg_addr_i == SLP_OFS_PERIODIC_ORIGIN);
    assign hit_qh     = (reg_addr_i == SLP_OFS_NEXT_QH_POINTER);

    // ********************************************************************
    // byte lane merge
    // ********************************************************************
    // lanes without an enable keep their current contents
    for (genvar lane = 0; lane < 4; lane++)
    begin : g_lane
        assign merged_origin[8*lane +: 8] = reg_be_i[lane] ? reg_wdata_i[8*lane +: 8]
                                                           : origin_word[8*lane +: 8];
        assign merged_qh[8*lane +: 8]     = reg_be_i[lane] ? reg_wdata_i[8*lane +: 8]
                                                           : qh_word[8*lane +: 8];
    end

    // ********************************************************************
    // periodic list origin
    // ********************************************************************
    // loaded by software before the periodic schedule is enabled
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            origin_field <= SLP_RESET_PERIODIC_ORIGIN[31:SLP_ORIGIN_LSB];
        end
        else if (reg_wr_i && hit_origin)
        begin
            origin_field <= merged_origin[31:SLP_ORIGIN_LSB];
        end
    end

    // ********************************************************************
    // next queue head pointer
    // ********************************************************************
    // bits 31..5 are all kept, 11..5 included; bits 4..0 are never stored
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            queue_head_link_field <= SLP_RESET_NEXT_QH_POINTER[31:SLP_QH_LSB];
        end
        else if (reg_wr_i && hit_qh)
        begin
            queue_head_link_field <= merged_qh[31:SLP_QH_LSB];
        end
    end

    // ********************************************************************
    // register read
    // ********************************************************************
    // one cycle read latency; unmapped offsets answer zero
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            reg_rdata_o  <= SLP_RDATA_IDLE;
            reg_rvalid_o <= 1'b0;
        end
        else
        begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i && hit_origin)
            begin
                reg_rdata_o <= origin_word;
            end
            else if (reg_rd_i && hit_qh)
            begin
                reg_rdata_o <= qh_word;
            end
            else
            begin
                reg_rdata_o <= SLP_RDATA_IDLE;
            end
        end
    end

    // ********************************************************************
    // frame list index selection
    // ********************************************************************
    // each entry serves eight microframes, so bits 2..0 are dropped
    always_comb
    begin
        next_index    = '0;
        next_size_bad = 1'b0;
        unique case (slp_size_e'(list_size_select_i))
            SLP_SIZE_1024:
            begin
                next_index = microframe_counter_i[SLP_N_1024:SLP_INDEX_LSB];
            end
            SLP_SIZE_512:
            begin
                next_index = {1'b0, microframe_counter_i[SLP_N_512:SLP_INDEX_LSB]};
            end
            SLP_SIZE_256:
            begin
                next_index = {2'b00, microframe_counter_i[SLP_N_256:SLP_INDEX_LSB]};
            end
            SLP_SIZE_RESERVED:
            begin
                // reserved size: park on entry zero rather than guess a size
                next_index    = '0;
                next_size_bad = 1'b1;
            end
        endcase
    end

    // ********************************************************************
    // entry fetch address forming
    // ********************************************************************
    assign periodic_low = {origin_field, next_index, {SLP_ENTRY_SHIFT{1'b0}}};

    slp_addr_form u_periodic_form
    (
        .low_addr_i                (periodic_low),
        .wide_addressing_capable_i (wide_addressing_capable_i),
        .upper_address_segment_i   (upper_address_segment_i),
        .full_addr_o               (periodic_full)
    );

    slp_addr_form u_queue_head_form
    (
        .low_addr_i                (qh_word),
        .wide_addressing_capable_i (wide_addressing_capable_i),
        .upper_address_segment_i   (upper_address_segment_i),
        .full_addr_o               (qh_full)
    );

    // ********************************************************************
    // registered addresses to the schedule engines
    // ********************************************************************
    // registering costs one cycle but keeps the long adder-free paths
    // from the counter and segment off the engines' fetch timing
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            periodic_fetch_addr_o <= 64'h0000_0000_0000_0000;
            queue_head_addr_o     <= 64'h0000_0000_0000_0000;
            list_size_bad_o       <= 1'b0;
        end
        else
        begin
            periodic_fetch_addr_o <= periodic_full;
            queue_head_addr_o     <= qh_full;
            list_size_bad_o       <= next_size_bad;
        end
    end

    // raw register contents for neighbouring logic
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            periodic_list_origin_o    <= SLP_RESET_PERIODIC_ORIGIN;
            next_queue_head_pointer_o <= SLP_RESET_NEXT_QH_POINTER;
        end
        else
        begin
            periodic_list_origin_o    <= origin_word;
            next_queue_head_pointer_o <= qh_word;
        end
    end

    // ********************************************************************
    // entry step detection
    // ********************************************************************
    // pulses when the selected entry moves on, every eighth microframe;
    // the index is tracked through reset so release shows no false step
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            index_q               <= next_index;
            periodic_entry_step_o <= 1'b0;
        end
        else
        begin
            index_q               <= next_index;
            periodic_entry_step_o <= (next_index != index_q);
        end
    end

endmodule : slp_regs

// File: slp_pkg.sv
// constants shared by the schedule list pointer register bank
package slp_pkg;

    // ********************************************************************
    // register offsets within the operational window
    // ********************************************************************
    localparam logic [7:0]  SLP_OFS_PERIODIC_ORIGIN = 8'h34;
    localparam logic [7:0]  SLP_OFS_NEXT_QH_POINTER = 8'h38;

    // ********************************************************************
    // field positions
    // ********************************************************************
    localparam int unsigned SLP_ORIGIN_LSB    = 12;  // origin maps onto address bits 31..12
    localparam int unsigned SLP_QH_LSB        = 5;   // bits 4..0 always read zero
    localparam int unsigned SLP_INDEX_LSB     = 3;   // counter bits N..3 select the entry
    localparam int unsigned SLP_ENTRY_SHIFT   = 2;   // four-byte list entries
    localparam int unsigned SLP_N_1024        = 12;
    localparam int unsigned SLP_N_512         = 11;
    localparam int unsigned SLP_N_256         = 10;
    localparam int unsigned SLP_INDEX_W       = SLP_N_1024 - SLP_INDEX_LSB + 1;

    // ********************************************************************
    // reset values
    // ********************************************************************
    localparam logic [31:0] SLP_RESET_PERIODIC_ORIGIN = 32'h0000_0000;
    localparam logic [31:0] SLP_RESET_NEXT_QH_POINTER = 32'h0000_0000;
    localparam logic [31:0] SLP_RDATA_IDLE            = 32'h0000_0000;

    // ********************************************************************
    // list size select encodings
    // ********************************************************************
    typedef enum logic [1:0]
    {
        SLP_SIZE_1024     = 2'b00,
        SLP_SIZE_512      = 2'b01,
        SLP_SIZE_256      = 2'b10,
        SLP_SIZE_RESERVED = 2'b11
    } slp_size_e;

endpackage : slp_pkg

// File: slp_addr_form.sv
// forms a 64-bit structure address from a 32-bit pointer and the segment
`timescale 1ns/10ps

module slp_addr_form
    import slp_pkg::*;
(
    input  wire logic [31:0] low_addr_i,
    input  wire logic        wide_addressing_capable_i,
    input  wire logic [31:0] upper_address_segment_i,
    output      logic [63:0] full_addr_o
);

    // ********************************************************************
    // segment selection
    // ********************************************************************
    // upper half is forced to zero in 32-bit mode so stale segment data
    // can never leak into a fetch address
    logic [31:0] upper_half;

    assign upper_half  = wide_addressing_capable_i ? upper_address_segment_i : 32'h0000_0000;
    assign full_addr_o = {upper_half, low_addr_i};

endmodule : slp_addr_form

// File: slp_regs_sva.sv
// concurrent checks on the schedule list pointer register bank ports
`timescale 1ns/10ps

module slp_regs_sva
    import slp_pkg::*;
#(
    parameter int unsigned COUNTER_W = 14
)
(
    input wire logic                 clk_sys_i,
    input wire logic                 reset_n_i,
    input wire logic [7:0]           reg_addr_i,
    input wire logic                 reg_wr_i,
    input wire logic                 reg_rd_i,
    input wire logic [3:0]           reg_be_i,
    input wire logic [31:0]          reg_wdata_i,
    input wire logic [31:0]          reg_rdata_o,
    input wire logic                 reg_rvalid_o,
    input wire logic                 wide_addressing_capable_i,
    input wire logic [31:0]          upper_address_segment_i,
    input wire logic [COUNTER_W-1:0] microframe_counter_i,
    input wire logic [1:0]           list_size_select_i,
    input wire logic [31:0]          periodic_list_origin_o,
    input wire logic [31:0]          next_queue_head_pointer_o,
    input wire logic [63:0]          periodic_fetch_addr_o,
    input wire logic [63:0]          queue_head_addr_o,
    input wire logic                 periodic_entry_step_o,
    input wire logic                 list_size_bad_o
);
    logic [9:0] idx;
    logic       mapped;

    // expected entry index; reserved size gives zero
    always_comb
    begin
        case (list_size_select_i)
            2'h0:    idx = microframe_counter_i[12:3];
            2'h1:    idx = {1'h0, microframe_counter_i[11:3]};
            2'h2:    idx = {2'h0, microframe_counter_i[10:3]};
            default: idx = 10'h0;
        endcase
    end
    assign mapped = (reg_addr_i == SLP_OFS_PERIODIC_ORIGIN)
                 || (reg_addr_i == SLP_OFS_NEXT_QH_POINTER);

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered");
    a_read_idle: assert property (!reg_rd_i |=> !reg_rvalid_o && reg_rdata_o == 32'h0)
        else $error("read port not idle");
    a_unmapped_zero: assert property (reg_rd_i && !mapped |=> reg_rdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_origin_write: assert property (
        (reg_wr_i && reg_addr_i == SLP_OFS_PERIODIC_ORIGIN && reg_be_i == 4'hf)
        ##1 !(reg_wr_i && reg_addr_i == SLP_OFS_PERIODIC_ORIGIN)
        |=> periodic_list_origin_o == ($past(reg_wdata_i, 2) & 32'hffff_f000))
        else $error("origin write lost");
    a_qh_low_zero: assert property (
        next_queue_head_pointer_o[4:0] == 5'h0 && queue_head_addr_o[4:0] == 5'h0)
        else $error("pointer low bits set");
    a_qh_follows: assert property (
        queue_head_addr_o[31:0] == next_queue_head_pointer_o)
        else $error("queue head address wrong");
    a_upper_segment: assert property (1'h1 |=>
        queue_head_addr_o[63:32] == periodic_fetch_addr_o[63:32]
        && queue_head_addr_o[63:32] == ($past(wide_addressing_capable_i)
        ? $past(upper_address_segment_i) : 32'h0))
        else $error("upper address wrong");
    a_fetch_index: assert property (1'h1 |=>
        periodic_fetch_addr_o[31:0] == {periodic_list_origin_o[31:12], $past(idx), 2'h0})
        else $error("fetch address wrong");
    a_size_flag: assert property (1'h1 |=>
        list_size_bad_o == ($past(list_size_select_i) == 2'h3))
        else $error("size flag wrong");
    a_step_pulse: assert property (1'h1 |=>
        periodic_entry_step_o == ($past(idx) != $past(idx, 2)))
        else $error("step pulse missing");
endmodule : slp_regs_sva

// File: slp_host_model.sv
// host software model issuing register writes and reads
`timescale 1ns/10ps

module slp_host_model
(
    input  wire logic        clk_sys_i,
    input  wire logic [31:0] rdata_i,
    input  wire logic        rvalid_i,
    output      logic [7:0]  addr_o,
    output      logic        wr_o,
    output      logic        rd_o,
    output      logic [3:0]  be_o,
    output      logic [31:0] wdata_o
);
    initial
    begin
        {addr_o, wr_o, rd_o, be_o, wdata_o} = '0;
    end

    // reserved bits zero unless raw; released lines show the inverse
    task automatic wr(input logic [7:0] a, input logic [3:0] b,
                      input logic [31:0] d, input logic raw);
        @(negedge clk_sys_i);
        addr_o = a;
        be_o = b;
        wdata_o = raw ? d : d & ((a == 8'h34) ? 32'hffff_f000 : 32'hffff_ffe0);
        wr_o = 1'h1;
        @(negedge clk_sys_i);
        wr_o = 1'h0;
        addr_o = ~addr_o;
        wdata_o = ~wdata_o;
    endtask : wr

    // answer is registered at the taking edge and sampled half a cycle later
    task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic v);
        @(negedge clk_sys_i);
        addr_o = a;
        rd_o = 1'h1;
        @(negedge clk_sys_i);
        q = rdata_i;
        v = rvalid_i;
        rd_o = 1'h0;
        addr_o = ~addr_o;
    endtask : rd
endmodule : slp_host_model

// File: slp_regs_bench.sv
// self-checking bench for the schedule list pointer register bank
`timescale 1ns/10ps

module slp_regs_bench;
    import slp_pkg::*;
    typedef struct packed {logic [7:0] a; logic [3:0] be; logic [31:0] d;
                           logic raw; logic [31:0] q;} slp_row_s;
    logic clk_sys_i = 1'h0, reset_n_i = 1'h0, reg_wr_i, reg_rd_i, reg_rvalid_o;
    logic wide_addressing_capable_i = 1'h0, periodic_entry_step_o, list_size_bad_o;
    logic [7:0] reg_addr_i;
    logic [3:0] reg_be_i;
    logic [1:0] list_size_select_i = 2'h0;
    logic [13:0] microframe_counter_i = 14'h0;
    logic [31:0] reg_wdata_i, reg_rdata_o, periodic_list_origin_o, next_queue_head_pointer_o;
    logic [31:0] upper_address_segment_i = 32'h5a5a_0001, q;
    logic [63:0] periodic_fetch_addr_o, queue_head_addr_o;
    logic v;
    int n_mismatch = 0, n_compared = 0, cycles = 0;
    slp_row_s rows [6] = '{'{8'h34, 4'hf, 32'h1234_5fff, 1'h1, 32'h1234_5000},
        '{8'h38, 4'hf, 32'habcd_e7ff, 1'h1, 32'habcd_e7e0},
        '{8'h38, 4'h2, 32'h0000_33ff, 1'h1, 32'habcd_33e0},
        '{8'h3c, 4'hf, 32'hffff_ffff, 1'h1, 32'h0},
        '{8'h34, 4'h8, 32'h9a00_0000, 1'h0, 32'h9a34_5000},
        '{8'h38, 4'hf, 32'h0004_0020, 1'h0, 32'h0004_0020}};

    slp_regs slp_regs_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_be_i(reg_be_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .wide_addressing_capable_i(wide_addressing_capable_i),
        .upper_address_segment_i(upper_address_segment_i),
        .microframe_counter_i(microframe_counter_i), .list_size_select_i(list_size_select_i),
        .periodic_list_origin_o(periodic_list_origin_o),
        .next_queue_head_pointer_o(next_queue_head_pointer_o),
        .periodic_fetch_addr_o(periodic_fetch_addr_o), .queue_head_addr_o(queue_head_addr_o),
        .periodic_entry_step_o(periodic_entry_step_o), .list_size_bad_o(list_size_bad_o));
    slp_host_model slp_host_model_inst (.clk_sys_i(clk_sys_i), .rdata_i(reg_rdata_o),
        .rvalid_i(reg_rvalid_o), .addr_o(reg_addr_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
        .be_o(reg_be_i), .wdata_o(reg_wdata_i));

    always #25 clk_sys_i = ~clk_sys_i;

    // hang guard: the whole run needs well under 400 cycles
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        slp_host_model_inst.rd(a, q, v);
        chk(64'({v, q}), 64'({1'h1, e}));
    endtask : rd_chk

    function automatic logic [63:0] exp_fetch(logic [31:0] o, logic [13:0] c, logic [1:0] s);
        logic [9:0] ix;
        ix = (s == 2'h0) ? c[12:3] : (s == 2'h1) ? {1'h0, c[11:3]}
           : (s == 2'h2) ? {2'h0, c[10:3]} : 10'h0;
        return {wide_addressing_capable_i ? upper_address_segment_i : 32'h0, o[31:12], ix, 2'h0};
    endfunction : exp_fetch

    task automatic conclude();
        if (n_mismatch == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (12) @(negedge clk_sys_i);
        chk(periodic_fetch_addr_o, 64'h0);
        chk(queue_head_addr_o, 64'h0);
        reset_n_i = 1'h1;
        rd_chk(8'h34, 32'h0);
        rd_chk(8'h38, 32'h0);
        // origin is written before the schedule is run
        foreach (rows[i])
        begin
            slp_host_model_inst.wr(rows[i].a, rows[i].be, rows[i].d, rows[i].raw);
            rd_chk(rows[i].a, rows[i].q);
        end
        chk({periodic_list_origin_o, next_queue_head_pointer_o}, 64'h9a34_5000_0004_0020);
        chk(queue_head_addr_o, 64'h0000_0000_0004_0020);
        wide_addressing_capable_i = 1'h1;
        microframe_counter_i = 14'h2af8;
        for (int s = 0; s < 4; s++)
        begin
            list_size_select_i = s[1:0];
            repeat (2) @(negedge clk_sys_i);
            chk(periodic_fetch_addr_o, exp_fetch(32'h9a34_5000, 14'h2af8, s[1:0]));
            chk(64'(list_size_bad_o), 64'(s == 3));
            chk(queue_head_addr_o, {upper_address_segment_i, 32'h0004_0020});
        end
        list_size_select_i = 2'h0;
        repeat (2) @(negedge clk_sys_i);
        microframe_counter_i = 14'h2b00;
        @(negedge clk_sys_i);
        chk(64'(periodic_entry_step_o), 64'h1);
        microframe_counter_i = 14'h2b01;
        @(negedge clk_sys_i);
        chk(64'(periodic_entry_step_o), 64'h0);
        chk(periodic_fetch_addr_o, exp_fetch(32'h9a34_5000, 14'h2b01, 2'h0));
        reset_n_i = 1'h0;
        repeat (2) @(negedge clk_sys_i);
        chk({periodic_list_origin_o, next_queue_head_pointer_o}, 64'h0);
        chk(periodic_fetch_addr_o, 64'h0);
        reset_n_i = 1'h1;
        // counter still selects a nonzero entry, so a stale index would pulse here
        @(negedge clk_sys_i);
        chk(64'(periodic_entry_step_o), 64'h0);
        rd_chk(8'h34, 32'h0);
        rd_chk(8'h38, 32'h0);
        conclude();
    end
endmodule : slp_regs_bench

bind slp_regs slp_regs_sva #(.COUNTER_W(COUNTER_W)) slp_regs_sva_inst (.clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_be_i(reg_be_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .wide_addressing_capable_i(wide_addressing_capable_i),
    .upper_address_segment_i(upper_address_segment_i),
    .microframe_counter_i(microframe_counter_i), .list_size_select_i(list_size_select_i),
    .periodic_list_origin_o(periodic_list_origin_o),
    .next_queue_head_pointer_o(next_queue_head_pointer_o),
    .periodic_fetch_addr_o(periodic_fetch_addr_o), .queue_head_addr_o(queue_head_addr_o),
    .periodic_entry_step_o(periodic_entry_step_o), .list_size_bad_o(list_size_bad_o));
